// ==== logic/ctc_params.svh ====
// constants for the capacitive touch control block: offsets, fields, resets, timing
// assumes byte-wide registers on a one-cycle register port clocked at 100 MHz
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH
`define CTC_ADDR_QLO     8'h18
`define CTC_ADDR_QHI     8'h19
`define CTC_ADDR_FEAT    8'h20
`define CTC_ADDR_WAIT    8'h21
`define CTC_ADDR_CALP    8'h22
`define CTC_ADDR_INTG    8'h23
`define CTC_ADDR_CTRL    8'h25
`define CTC_ADDR_MASK    8'h26
`define CTC_ADDR_CLR     8'h27
`define CTC_ADDR_SCNT    8'h28
`define CTC_ADDR_SLIM    8'h29
`define CTC_ADDR_RSC     8'h2A
`define CTC_PAGE_TVR     5'h06
`define CTC_ADDR_AVAR    8'h40
`define CTC_PAGE_SLMT    5'h0A
`define CTC_ADDR_TSTAT   8'h90
`define CTC_ADDR_PEND    8'h92
`define CTC_RST_FEAT     8'h04
`define CTC_RST_WAIT     8'h27
`define CTC_RST_CALP     8'h30
`define CTC_RST_INTG     8'h0F
`define CTC_RST_MASK     8'h08
`define CTC_RST_TVR      7'h08
`define CTC_RST_AVAR     7'h04
`define CTC_RST_SLMT     8'h01
`define CTC_FEAT_FILT    0
`define CTC_CTRL_HOLD    0
`define CTC_CTRL_HCC     1
`define CTC_CTRL_HCU     2
`define CTC_CTRL_FACT    3
`define CTC_EV_A2S       1
`define CTC_EV_S2A       2
`define CTC_EV_EOC       3
`define CTC_CLK_PERIOD_NS    10
`define CTC_SENSOR_PERIOD_NS 1000
`define CTC_SENSOR_DIV   (`CTC_SENSOR_PERIOD_NS / `CTC_CLK_PERIOD_NS)
`define CTC_TRACK_SCALE  16'd64
`define CTC_CAL_SCALE    16'd50
`define CTC_CAL_TICKS    4'd4
`define CTC_SLEEP_TICKS  16'd32
`define CTC_QUEUE_DEPTH  4
`endif

// ==== logic/ctc_pkg.sv ====
// types shared by the capacitive touch control block
// assumes ctc_params.svh carries all numeric constants
package ctc_pkg;
   typedef logic [7:0] ctc_byte_t;
   typedef enum logic {
      CTC_PWR_ACTIVE = 1'b0,
      CTC_PWR_SLEEP  = 1'b1
   } ctc_pwr_t;
   typedef enum logic {
      CTC_CAL_IDLE = 1'b0,
      CTC_CAL_RUN  = 1'b1
   } ctc_cal_t;
endpackage

// ==== logic/ctc_fifo_if.sv ====
// valid/ready carrier between the touch control logic and its snapshot queue
// assumes both ends share one clock
interface ctc_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 4);
   logic                           in_valid;
   logic                           in_ready;
   logic [WIDTH-1:0]               in_data;
   logic                           out_valid;
   logic                           out_ready;
   logic [WIDTH-1:0]               out_data;
   logic [$clog2(DEPTH+1)-1:0]     level;
   modport store (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, level);
   modport user  (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data, level);
endinterface

// ==== logic/ctc_fifo.sv ====
// snapshot queue: first-in first-out store with valid/ready on both sides
// assumes DEPTH is a power of two so the pointers wrap by themselves
module ctc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock,      // system clock
   input wire logic reset,      // synchronous, active high
   ctc_fifo_if.store q          // fill and drain sides
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [LW-1:0]    level_reg;
   wire              push_fire = q.in_valid & q.in_ready;
   wire              pop_fire  = q.out_valid & q.out_ready;

   // a full queue refuses the push; the source drops the snapshot
   assign q.in_ready  = level_reg != LW'(DEPTH);
   assign q.out_valid = level_reg != '0;
   assign q.out_data  = mem_reg[rd_ptr_reg];
   assign q.level     = level_reg;

   always_ff @(posedge clock) begin
      if (push_fire) begin
         mem_reg[wr_ptr_reg] <= q.in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push_fire);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop_fire);
         level_reg  <= level_reg + LW'(push_fire) - LW'(pop_fire);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   full_no_overwrite_a: assert property (q.in_valid && !q.in_ready && !pop_fire |=>
      $stable(level_reg) && $stable(wr_ptr_reg))
      else $error("full queue accepted a snapshot");
endmodule

// ==== logic/ctc_top.sv ====
// capacitive touch control: register file, filtering, calibration, sleep and queue
// assumes a one-cycle byte register port from the serial bus slave on the same clock
`include "ctc_params.svh"

module ctc_top
   import ctc_pkg::*;
#(
   parameter int SENSOR_DIV = `CTC_SENSOR_DIV
) (
   input  wire logic       clock,         // 100 MHz system clock
   input  wire logic       reset,         // synchronous, active high
   input  wire logic [7:0] reg_addr,      // register byte address
   input  wire logic       reg_wr,        // write strobe, one cycle
   input  wire logic       reg_rd,        // read strobe, one cycle
   input  wire logic [7:0] reg_wdata,     // write data
   output logic      [7:0] reg_rdata,     // read data, valid the cycle after reg_rd
   input  wire logic [7:0] sense_touch,   // raw per-channel touch from the front end
   output logic      [6:0] range_shift,   // reference offset to the front end
   output logic            cal_active,    // calibration running
   output logic            unit_active,   // high while awake
   output logic      [7:0] touch_status,  // current valid touch per channel
   output logic            queue_avail,   // queue holds at least one snapshot
   output logic            sys_event      // unmasked pending event present
);
   ctc_byte_t feat_reg, wait_reg, calp_reg, intg_reg, ctrl_reg, mask_reg;
   ctc_byte_t scnt_reg, slim_reg, rsc_reg, tstat_reg, pend_reg;
   logic [6:0] avar_reg;
   logic [6:0] tvr_reg  [8];
   ctc_byte_t  slmt_reg [8];
   ctc_byte_t  str_reg  [8];
   ctc_byte_t  fcnt_reg [8];
   logic [7:0] sense_meta_reg, sense_sync_reg;
   logic [15:0] div_reg, quiet_cnt_reg, since_cal_reg;
   ctc_byte_t  win_reg;
   logic [3:0] cal_cnt_reg;
   logic       quiet_reg, cal_host_reg;
   ctc_pwr_t   pwr_reg, pwr_next;
   ctc_cal_t   cal_reg, cal_next;

   ctc_fifo_if #(.WIDTH(8), .DEPTH(`CTC_QUEUE_DEPTH)) q ();

   ctc_fifo #(.WIDTH(8), .DEPTH(`CTC_QUEUE_DEPTH)) u_queue (
      .clock (clock),
      .reset (reset),
      .q     (q)
   );

   // register decode
   wire wr_feat = reg_wr && reg_addr == `CTC_ADDR_FEAT;
   wire wr_wait = reg_wr && reg_addr == `CTC_ADDR_WAIT;
   wire wr_calp = reg_wr && reg_addr == `CTC_ADDR_CALP;
   wire wr_intg = reg_wr && reg_addr == `CTC_ADDR_INTG;
   wire wr_ctrl = reg_wr && reg_addr == `CTC_ADDR_CTRL;
   wire wr_mask = reg_wr && reg_addr == `CTC_ADDR_MASK;
   wire wr_clr  = reg_wr && reg_addr == `CTC_ADDR_CLR;
   wire wr_scnt = reg_wr && reg_addr == `CTC_ADDR_SCNT;
   wire wr_slim = reg_wr && reg_addr == `CTC_ADDR_SLIM;
   wire wr_rsc  = reg_wr && reg_addr == `CTC_ADDR_RSC;
   wire wr_avar = reg_wr && reg_addr == `CTC_ADDR_AVAR;
   wire in_tvr  = reg_addr[7:3] == `CTC_PAGE_TVR;
   wire in_slmt = reg_addr[7:3] == `CTC_PAGE_SLMT;
   wire [2:0] ch_idx = reg_addr[2:0];

   // sensor clock as an enable pulse
   wire tick = div_reg == 16'(SENSOR_DIV - 1);
   always_ff @(posedge clock) begin
      if (reset || tick) div_reg <= '0;
      else div_reg <= div_reg + 16'd1;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         sense_meta_reg <= '0;
         sense_sync_reg <= '0;
      end else begin
         sense_meta_reg <= sense_touch;
         sense_sync_reg <= sense_meta_reg;
      end
   end

   // integration window, counted in sensor ticks
   wire       afs_on    = |feat_reg[3:1];
   wire [7:0] win_last  = (intg_reg == 8'h00) ? 8'h00 : intg_reg - 8'h01;
   wire       win_end   = tick && win_reg >= win_last;
   wire       samp_on   = win_reg < scnt_reg;
   wire       filt_en   = feat_reg[`CTC_FEAT_FILT];
   always_ff @(posedge clock) begin
      if (reset || win_end) win_reg <= '0;
      else if (tick) win_reg <= win_reg + 8'h01;
   end

   logic [7:0] ch_next, ch_quiet;
   for (genvar i = 0; i < 8; i++) begin : g_ch
      // the tick that closes a window still counts, so strength can reach the window length
      wire [7:0] str_now  = str_reg[i] + 8'(tick & sense_sync_reg[i]);
      wire [7:0] fcnt_now = fcnt_reg[i] + 8'(tick & sense_sync_reg[i] & samp_on);
      wire str_ok  = str_now >= slmt_reg[i];
      wire filt_ok = !filt_en || fcnt_now >= slim_reg;
      assign ch_next[i]  = afs_on ? (str_ok && filt_ok) : sense_sync_reg[i];
      // no-touch means strength stayed under the ambient variance, or in plain mode an idle input
      assign ch_quiet[i] = afs_on ? (str_now < {1'b0, avar_reg})
                                  : !sense_sync_reg[i];
      always_ff @(posedge clock) begin
         if (reset || win_end) begin
            str_reg[i]  <= '0;
            fcnt_reg[i] <= '0;
         end else if (tick && sense_sync_reg[i]) begin
            str_reg[i]  <= str_reg[i] + 8'h01;
            fcnt_reg[i] <= samp_on ? fcnt_reg[i] + 8'h01 : fcnt_reg[i];
         end
      end
   end

   // with feature bits 3:1 clear the status follows the inputs; with any of them set, once per window
   wire status_upd = afs_on ? win_end : 1'b1;
   wire status_chg = status_upd && ch_next != tstat_reg;
   assign q.in_valid  = status_chg;
   assign q.in_data   = ch_next;
   assign q.out_ready = reg_rd && reg_addr == `CTC_ADDR_QHI;

   always_ff @(posedge clock) begin
      if (reset) begin
         tstat_reg <= '0;
         quiet_reg <= 1'b1;
      end else if (status_upd) begin
         tstat_reg <= ch_next;
         quiet_reg <= &ch_quiet;
      end
   end

   // calibration scheduling
   wire [15:0] etc_need  = 16'(wait_reg) * `CTC_TRACK_SCALE;
   wire [15:0] cal_need  = 16'(calp_reg) * `CTC_CAL_SCALE;
   wire        hold      = ctrl_reg[`CTC_CTRL_HOLD];
   wire        cal_idle  = cal_reg == CTC_CAL_IDLE;
   wire        etc_go    = cal_idle && !hold && quiet_reg
                           && quiet_cnt_reg >= etc_need && since_cal_reg >= cal_need;
   wire        hcu_go    = ctrl_reg[`CTC_CTRL_HCU];
   wire        hcc_go    = ctrl_reg[`CTC_CTRL_HCC] && tstat_reg == 8'h00;
   wire        host_go   = cal_idle && hold && (hcu_go || hcc_go);
   wire        cal_start = etc_go || host_go;
   wire        cal_done  = cal_reg == CTC_CAL_RUN && tick
                           && cal_cnt_reg == `CTC_CAL_TICKS - 4'd1;

   always_comb begin
      cal_next = cal_reg;
      unique case (cal_reg)
         CTC_CAL_IDLE: if (cal_start) cal_next = CTC_CAL_RUN;
         CTC_CAL_RUN:  if (cal_done) cal_next = CTC_CAL_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cal_reg      <= CTC_CAL_IDLE;
         cal_cnt_reg  <= '0;
         cal_host_reg <= 1'b0;
      end else begin
         cal_reg      <= cal_next;
         cal_cnt_reg  <= cal_idle ? 4'd0 : cal_cnt_reg + 4'(tick);
         cal_host_reg <= cal_start ? host_go : cal_host_reg;
      end
   end

   // tick counters saturate so long quiet spells never wrap
   always_ff @(posedge clock) begin
      if (reset || !quiet_reg) quiet_cnt_reg <= '0;
      else if (tick && quiet_cnt_reg != 16'hFFFF) quiet_cnt_reg <= quiet_cnt_reg + 16'd1;
   end
   always_ff @(posedge clock) begin
      if (reset || cal_done) since_cal_reg <= '0;
      else if (tick && since_cal_reg != 16'hFFFF) since_cal_reg <= since_cal_reg + 16'd1;
   end

   // sleep and wake
   wire force_act = ctrl_reg[`CTC_CTRL_FACT];
   wire go_sleep  = pwr_reg == CTC_PWR_ACTIVE && !force_act && cal_idle
                    && quiet_cnt_reg >= `CTC_SLEEP_TICKS;
   wire go_wake   = pwr_reg == CTC_PWR_SLEEP && (force_act || !quiet_reg);
   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         CTC_PWR_ACTIVE: if (go_sleep) pwr_next = CTC_PWR_SLEEP;
         CTC_PWR_SLEEP:  if (go_wake) pwr_next = CTC_PWR_ACTIVE;
      endcase
   end
   always_ff @(posedge clock) begin
      if (reset) pwr_reg <= CTC_PWR_ACTIVE;
      else pwr_reg <= pwr_next;
   end

   // pending events: a new event wins over a same-cycle clear
   wire [7:0] ev_set = {4'h0, cal_done, go_wake, go_sleep, 1'b0};
   wire [7:0] ev_clr = wr_clr ? {4'h0, reg_wdata[3:1], 1'b0} : 8'h00;
   always_ff @(posedge clock) begin
      if (reset) pend_reg <= '0;
      else pend_reg <= (pend_reg & ~ev_clr) | ev_set;
   end

   // host register writes; a host write to control wins over the completion clear
   always_ff @(posedge clock) begin
      if (reset) begin
         feat_reg <= `CTC_RST_FEAT;
         wait_reg <= `CTC_RST_WAIT;
         calp_reg <= `CTC_RST_CALP;
         intg_reg <= `CTC_RST_INTG;
         mask_reg <= `CTC_RST_MASK;
         scnt_reg <= '0;
         slim_reg <= '0;
         rsc_reg  <= '0;
         avar_reg <= `CTC_RST_AVAR;
      end else begin
         if (wr_feat) feat_reg <= {4'h0, reg_wdata[3:0]};
         if (wr_wait) wait_reg <= reg_wdata;
         if (wr_calp) calp_reg <= reg_wdata;
         if (wr_intg) intg_reg <= reg_wdata;
         if (wr_mask) mask_reg <= {4'h0, reg_wdata[3:1], 1'b0};
         if (wr_scnt) scnt_reg <= reg_wdata;
         if (wr_slim) slim_reg <= reg_wdata;
         if (wr_rsc) rsc_reg <= {1'b0, reg_wdata[6:0]};
         if (wr_avar) avar_reg <= reg_wdata[6:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) ctrl_reg <= '0;
      else if (wr_ctrl) ctrl_reg <= {4'h0, reg_wdata[3:0]};
      else if (cal_done && cal_host_reg) ctrl_reg <= ctrl_reg & 8'hF9;
   end

   for (genvar i = 0; i < 8; i++) begin : g_tab
      always_ff @(posedge clock) begin
         if (reset) begin
            tvr_reg[i]  <= `CTC_RST_TVR;
            slmt_reg[i] <= `CTC_RST_SLMT;
         end else if (reg_wr && ch_idx == 3'(i)) begin
            if (in_tvr) tvr_reg[i] <= reg_wdata[6:0];
            if (in_slmt) slmt_reg[i] <= reg_wdata;
         end
      end
   end

   // read selection; unmapped and reserved locations read zero
   wire [7:0] q_head  = q.out_valid ? q.out_data : 8'h00;
   wire [7:0] rd_mux  =
      reg_addr == `CTC_ADDR_QLO  ? q_head :
      reg_addr == `CTC_ADDR_FEAT ? feat_reg :
      reg_addr == `CTC_ADDR_WAIT ? wait_reg :
      reg_addr == `CTC_ADDR_CALP ? calp_reg :
      reg_addr == `CTC_ADDR_INTG ? intg_reg :
      reg_addr == `CTC_ADDR_CTRL ? ctrl_reg :
      reg_addr == `CTC_ADDR_MASK ? mask_reg :
      reg_addr == `CTC_ADDR_SCNT ? scnt_reg :
      reg_addr == `CTC_ADDR_SLIM ? slim_reg :
      reg_addr == `CTC_ADDR_RSC  ? rsc_reg :
      in_tvr                     ? {1'b0, tvr_reg[ch_idx]} :
      reg_addr == `CTC_ADDR_AVAR ? {1'b0, avar_reg} :
      in_slmt                    ? slmt_reg[ch_idx] :
      reg_addr == `CTC_ADDR_TSTAT ? tstat_reg :
      reg_addr == `CTC_ADDR_PEND ? pend_reg : 8'h00;

   always_ff @(posedge clock) begin
      if (reset) reg_rdata <= '0;
      else if (reg_rd) reg_rdata <= rd_mux;
   end

   assign range_shift  = rsc_reg[6:0];
   assign cal_active   = cal_reg == CTC_CAL_RUN;
   assign unit_active  = pwr_reg == CTC_PWR_ACTIVE;
   assign touch_status = tstat_reg;
   assign queue_avail  = q.out_valid;
   assign sys_event    = |(pend_reg[3:1] & ~mask_reg[3:1]);

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   feat_reset_val_a: assert property ($fell(reset) |-> feat_reg == 8'h04)
      else $error("feature select reset value wrong");
   empty_read_zero_a: assert property (reg_rd && reg_addr == 8'h18 && q.level == 0
      |=> reg_rdata == 8'h00)
      else $error("empty queue read not zero");
   hi_read_pop_a: assert property (q.out_ready && q.out_valid && !q.in_valid
      |=> q.level == $past(q.level) - 1)
      else $error("high byte read did not pop");
   tracking_wait_time_gate_a: assert property (etc_go |-> quiet_cnt_reg >= 16'(wait_reg) * 16'd64)
      else $error("tracking calibration before wait time");
   host_cal_hold_a: assert property (cal_start && !hold |-> !host_go)
      else $error("host calibration while tracking enabled");
   hcu_self_clear_a: assert property (cal_done && cal_host_reg && !wr_ctrl
      |=> !ctrl_reg[2] && !ctrl_reg[1])
      else $error("host calibration bit not cleared");
   eoc_pending_a: assert property (cal_done |=> pend_reg[3])
      else $error("calibration end not recorded");
   clear_pending_a: assert property (wr_clr && reg_wdata[2] && !go_wake
      |=> !pend_reg[2])
      else $error("pending wake not cleared");
   force_active_a: assert property (unit_active && force_act |=> unit_active)
      else $error("entered sleep while forced active");
   queue_flag_a: assert property (queue_avail == (q.level != 0))
      else $error("queue available flag wrong");
   mask_reset_val_a: assert property ($fell(reset) |-> mask_reg == 8'h08)
      else $error("mask reset value wrong");
   host_cal_gate_a: assert property (cal_start && hold |-> ctrl_reg[2] || (ctrl_reg[1] && tstat_reg == 8'h00))
      else $error("host calibration without a valid request");
   status_hold_a: assert property (afs_on && !win_end |=> $stable(tstat_reg))
      else $error("filtered status changed inside a window");

   // a sleep or wake sets its pending bit on the same edge as the state change
   sleep_event_a: assert property ($fell(unit_active) |-> pend_reg[1])
      else $error("sleep entry not recorded");
   wake_event_a: assert property ($rose(unit_active) |-> pend_reg[2])
      else $error("wake not recorded");
endmodule

// ==== verification/ctc_host_model.sv ====
// host side of the register port: byte writes, byte reads and two-byte queue entry reads
// assumes a one-cycle registered read answer on the same clock as the bench
module ctc_host_model (
   input  wire logic       clock,     // system clock
   output logic      [7:0] reg_addr,  // register address
   output logic            reg_wr,    // write strobe
   output logic            reg_rd,    // read strobe
   output logic      [7:0] reg_wdata, // write data
   input  wire logic [7:0] reg_rdata  // read data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
   // entries are read at the low-byte port and popped by the high-byte read, low byte first
   task automatic read_queue(output logic [7:0] lo, output logic [7:0] hi);
      read_reg(8'h18, lo);
      read_reg(8'h19, hi);
   endtask
endmodule

// ==== verification/ctc_top_bench.sv ====
// self-checking bench for ctc_top: registers, queue, sleep, calibration, filter
// assumes the host model owns the register port and a sensor tick of two clocks
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", what, exp, got); end end
module ctc_top_bench
   import ctc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DIV = 2;
   localparam logic [7:0] RA [15] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h28,
                                      8'h29, 8'h2A, 8'h30, 8'h40, 8'h50, 8'h90, 8'h24};
   localparam logic [7:0] RV [15] = '{8'h04, 8'h27, 8'h30, 8'h0F, 8'h00, 8'h08, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h08, 8'h04, 8'h01, 8'h00, 8'h00};
   // write masks: reserved bits read back as zero, 0x2A last so range_shift can be seen
   localparam logic [7:0] WA [10] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h26, 8'h28, 8'h29,
                                      8'h30, 8'h50, 8'h2A};
   localparam logic [7:0] WM [10] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h0E, 8'hFF, 8'hFF,
                                      8'h7F, 8'hFF, 8'h7F};
   logic        clock;
   logic        reset;
   logic        reg_wr;
   logic        reg_rd;
   logic        cal_active;
   logic        unit_active;
   logic        queue_avail;
   logic        sys_event;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [7:0]  sense_touch;
   logic [7:0]  touch_status;
   logic [6:0]  range_shift;
   logic [31:0] seed;
   ctc_byte_t   d;
   ctc_byte_t   e;
   ctc_byte_t   h;
   ctc_byte_t   q[$];
   int          fail_count;
   int          cmp_count;
   int          n;
   ctc_top #(.SENSOR_DIV(DIV)) dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sense_touch(sense_touch), .range_shift(range_shift), .cal_active(cal_active),
      .unit_active(unit_active), .touch_status(touch_status), .queue_avail(queue_avail),
      .sys_event(sys_event));
   ctc_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clock);
      #1 reset = 1'b1;
      repeat (20) @(posedge clock);
      #1 reset = 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] v);
      host.read_reg(a, d);
      `CHK($sformatf("register %h", a), v, d)
   endtask
   // bounded wait: 0 asleep, 1 calibrating, 2 channel zero touched
   task automatic wait_on(input int sel, input int lim);
      n = 0;
      while (!(sel == 0 ? unit_active === 1'b0 : sel == 1 ? cal_active === 1'b1 :
               touch_status === 8'h01)) begin
         @(posedge clock);
         #1 n++;
         if (n > lim) begin
            fail_count++;
            tally_and_finish();
         end
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      reset = 1'b1;
      sense_touch = 8'h00;
      seed = 32'd11820;
      fail_count = 0;
      cmp_count = 0;
      repeat (20) @(posedge clock);
      #1 reset = 1'b0;
      foreach (RA[i]) chk_reg(RA[i], RV[i]);
      foreach (WA[i]) begin
         h = 8'(xs());
         host.write_reg(WA[i], h);
         chk_reg(WA[i], h & WM[i]);
      end
      `CHK("range_shift", h[6:0], range_shift)
      do_reset();
      host.write_reg(8'h20, 8'h00);
      host.write_reg(8'h25, 8'h09);
      h = 8'h00;
      for (int i = 0; i < 5; i++) begin
         h = h ^ (8'(xs()) | 8'h01);
         sense_touch = h;
         if (i < 4) q.push_back(h);
         repeat (6) @(posedge clock);
         #1;
      end
      `CHK("touch_status", h, touch_status)
      `CHK("queue_avail", 1'b1, queue_avail)
      for (int i = 0; i < 4; i++) begin
         host.read_queue(d, e);
         `CHK("snapshot", q[i], d)
         `CHK("high byte", 8'h00, e)
      end
      host.read_queue(d, e);
      `CHK("empty read", 8'h00, d)
      `CHK("queue_avail", 1'b0, queue_avail)
      do_reset();
      sense_touch = 8'h00;
      // plain mode so the status follows the inputs within a few clocks
      host.write_reg(8'h20, 8'h00);
      host.write_reg(8'h25, 8'h01);
      wait_on(0, 200);
      chk_reg(8'h92, 8'h02);
      `CHK("sys_event", 1'b1, sys_event)
      host.write_reg(8'h26, 8'h02);
      chk_reg(8'h26, 8'h02);
      `CHK("sys_event", 1'b0, sys_event)
      host.write_reg(8'h27, 8'h02);
      chk_reg(8'h92, 8'h00);
      host.write_reg(8'h25, 8'h09);
      chk_reg(8'h92, 8'h04);
      repeat (100) @(posedge clock);
      #1 `CHK("unit_active", 1'b1, unit_active)
      host.write_reg(8'h25, 8'h0D);
      wait_on(1, 20);
      repeat (12) @(posedge clock);
      chk_reg(8'h25, 8'h09);
      chk_reg(8'h92, 8'h0C);
      sense_touch = 8'h01;
      repeat (8) @(posedge clock);
      host.write_reg(8'h25, 8'h0B);
      repeat (20) @(posedge clock);
      #1 `CHK("cal_active", 1'b0, cal_active)
      sense_touch = 8'h00;
      wait_on(1, 30);
      repeat (12) @(posedge clock);
      chk_reg(8'h25, 8'h09);
      do_reset();
      host.write_reg(8'h21, 8'h01);
      host.write_reg(8'h22, 8'h01);
      host.write_reg(8'h25, 8'h08);
      wait_on(1, 400);
      `CHK("quiet wait", 1'b1, n >= 100)
      do_reset();
      host.write_reg(8'h25, 8'h09);
      host.write_reg(8'h23, 8'h04);
      host.write_reg(8'h20, 8'h02);
      sense_touch = 8'h01;
      wait_on(2, 60);
      // a strength limit above the window length can never be met
      host.write_reg(8'h50, 8'h05);
      repeat (40) @(posedge clock);
      #1 `CHK("touch_status", 8'h00, touch_status)
      // filter on with no sampled slots: the filter count stays under the threshold
      host.write_reg(8'h29, 8'h02);
      host.write_reg(8'h20, 8'h03);
      host.write_reg(8'h50, 8'h01);
      repeat (40) @(posedge clock);
      #1 `CHK("touch_status", 8'h00, touch_status)
      host.write_reg(8'h28, 8'h04);
      wait_on(2, 60);
      tally_and_finish();
   end
endmodule
